/* File: pkg/txtest_pkg.sv */
`default_nettype none
package txtest_pkg;

	// ************************************************************
	// Register map (byte addresses on the AHB-Lite bus)
	// ************************************************************
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_DAC      = 8'h04;
	localparam logic [7:0] OFS_STROBE   = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_TXBUF    = 8'h10;
	localparam logic [7:0] OFS_CRC      = 8'h14;

	// Strobe register bit positions.
	localparam int STB_OSC_ON  = 0;
	localparam int STB_TX_ON   = 1;
	localparam int STB_TX_OFF  = 2;
	localparam int STB_FLUSH   = 3;

	// Reset values and fixed patterns.
	localparam logic [1:0]  MODE_RST      = 2'h0;
	localparam logic [15:0] DAC_RST       = 16'h0000;
	localparam logic [15:0] DAC_CARRIER   = 16'h1800;
	localparam logic [15:0] CRC_RST       = 16'h0000;
	localparam logic [7:0]  CRC_FEED      = 8'hFF;
	localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [7:0]  PREAMBLE_BYTE = 8'h00;
	localparam logic [7:0]  SFD_BYTE      = 8'hA7;
	localparam int          PREAMBLE_LEN  = 4;

	// Transmit test selection values.
	localparam logic [1:0] MODE_REPLAY = 2'h2;
	localparam logic [1:0] MODE_PRBS   = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_HEADER  = 2'b01,
		ST_PAYLOAD = 2'b10,
		ST_CARRIER = 2'b11
	} tx_state_e;

	// Captured AHB address phase.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} bus_phase_s;

	// Static DAC drive towards the analog transmitter.
	typedef struct packed {
		logic        override_en;
		logic [15:0] value;
	} dac_drive_s;

endpackage
`default_nettype wire

/* File: rtl/tx_test_pattern_generator.sv */
// Functional notes
// - A carrier is requested by test selection 2 or 3, the override word 0x1800 and the transmit-on strobe.
// - With the carrier value in the override word the transmitter is on and the DACs are held at static values.
// - Test selection 3 plus the transmit-on strobe sends a pseudo-random sequence from the CRC generator.
// - Each pseudo-random byte is the CRC low byte, after which the CRC is advanced by feeding 0xFF.
// - The pseudo-random sequence repeats every 32767 bytes.
// - The pseudo-random payload starts 0x00, 0x78, 0xb8, 0x4b, 0x99, 0xc3, 0xe9 and carries on from the CRC.
// - Every transmission, test modes included, begins with preamble and start-of-frame delimiter.
// - Test selection 2 replays the transmit buffer forever and ignores underflow.
// - Replay repeats every 1024 bits, the whole 128-byte transmit buffer.
`timescale 1ns/1ps
`default_nettype none
module tx_test_pattern_generator
	import txtest_pkg::*;
#(
	parameter int BUF_DEPTH = 128
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Oscillator control and its stability pin.
	output logic             osc_enable,
	input  wire logic        osc_stable_pin,
	// Byte stream towards the modulator.
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// Transmitter enable and static DAC drive.
	output logic             tx_enable,
	output dac_drive_s       dac_drive
);

	localparam int AW = $clog2(BUF_DEPTH);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// The fill count is reported in an 8-bit status field, so deeper buffers cannot be served.
	if (BUF_DEPTH < 2 || BUF_DEPTH > 128 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
		$error("BUF_DEPTH must be a power of two from 2 to 128");
	end

	// ************************************************************
	// Functions
	// ************************************************************
	// One byte through the reflected CRC, least significant bit first.
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] din);
		logic [15:0] c;
		c = crc ^ {8'h00, din};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		return c;
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]      mem [BUF_DEPTH];
	bus_phase_s      ph_r, ph_nxt;
	logic [31:0]     rdata_r, rdata_nxt;
	logic [1:0]      mode_r, mode_nxt;
	logic [15:0]     dac_r, dac_nxt;
	logic            osc_en_r, osc_en_nxt;
	logic [AW-1:0]   wr_ptr_r, wr_ptr_nxt;
	logic [AW:0]     count_r, count_nxt;
	logic            sync1_r, sync2_r, sync3_r, stable_r, stable_nxt;
	tx_state_e       state_r, state_nxt;
	logic [7:0]      byte_r, byte_nxt;
	logic [15:0]     crc_r, crc_nxt;
	logic [AW-1:0]   rd_ptr_r, rd_ptr_nxt;
	logic [AW:0]     sent_r, sent_nxt;
	logic [2:0]      hdr_r, hdr_nxt;
	logic            buf_we;
	logic            stb_tx_on, stb_tx_off, stb_flush;
	logic            carrier_req;
	logic            take;

	// ************************************************************
	// Bus slave and registers
	// ************************************************************
	// Zero wait state slave; every response is OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;

	// Next values of the bus phase, the control registers and the buffer fill.
	always_comb begin
		ph_nxt      = '{wr: 1'b0, rd: 1'b0, addr: 8'h00};
		rdata_nxt   = rdata_r;
		mode_nxt    = mode_r;
		dac_nxt     = dac_r;
		osc_en_nxt  = osc_en_r;
		wr_ptr_nxt  = wr_ptr_r;
		count_nxt   = count_r;
		buf_we      = 1'b0;
		stb_tx_on   = 1'b0;
		stb_tx_off  = 1'b0;
		stb_flush   = 1'b0;
		if (hsel && htrans[1] && hready) begin
			ph_nxt.wr   = hwrite;
			ph_nxt.rd   = !hwrite;
			ph_nxt.addr = {haddr[7:2], 2'b00};
			// Read data is fetched in the address phase so it stands from a flop.
			if (!hwrite) begin
				if ({haddr[7:2], 2'b00} == OFS_MODE) begin
					rdata_nxt = {30'h0000_0000, mode_r};
				end else if ({haddr[7:2], 2'b00} == OFS_DAC) begin
					rdata_nxt = {16'h0000, dac_r};
				end else if ({haddr[7:2], 2'b00} == OFS_STATUS) begin
					// Fill count in bits 15:8, state in 3:2, enable in 1, synced stability in 0.
					rdata_nxt       = 32'h0000_0000;
					rdata_nxt[15:8] = 8'(count_r);
					rdata_nxt[3:2]  = state_r;
					rdata_nxt[1]    = osc_en_r;
					rdata_nxt[0]    = stable_r;
				end else if ({haddr[7:2], 2'b00} == OFS_CRC) begin
					rdata_nxt = {16'h0000, crc_r};
				end else begin
					rdata_nxt = 32'h0000_0000;
				end
			end
		end
		// Write data arrives in the data phase.
		if (ph_r.wr) begin
			if (ph_r.addr == OFS_MODE) begin
				mode_nxt = hwdata[1:0];
			end else if (ph_r.addr == OFS_DAC) begin
				dac_nxt = hwdata[15:0];
			end else if (ph_r.addr == OFS_STROBE) begin
				osc_en_nxt = osc_en_r | hwdata[STB_OSC_ON];
				stb_tx_on  = hwdata[STB_TX_ON];
				stb_tx_off = hwdata[STB_TX_OFF];
				stb_flush  = hwdata[STB_FLUSH];
			end else if (ph_r.addr == OFS_TXBUF) begin
				// A full buffer drops further bytes rather than overwrite them.
				if (count_r != BUF_DEPTH[AW:0]) begin
					buf_we     = 1'b1;
					wr_ptr_nxt = wr_ptr_r + 1'b1;
					count_nxt  = count_r + 1'b1;
				end
			end
		end
		if (stb_flush) begin
			wr_ptr_nxt = '0;
			count_nxt  = '0;
		end
	end

	// Register stage of the bus and control group.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r     <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00};
			rdata_r  <= 32'h0000_0000;
			mode_r   <= MODE_RST;
			dac_r    <= DAC_RST;
			osc_en_r <= 1'b0;
			wr_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			ph_r     <= ph_nxt;
			rdata_r  <= rdata_nxt;
			mode_r   <= mode_nxt;
			dac_r    <= dac_nxt;
			osc_en_r <= osc_en_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	// Buffer storage has no reset; only written bytes are ever meaningful.
	always_ff @(posedge hclk) begin
		if (buf_we) begin
			mem[wr_ptr_r] <= hwdata[7:0];
		end
	end

	// ************************************************************
	// Oscillator stability synchroniser
	// ************************************************************
	// The stable level changes only once the second and third stages agree.
	always_comb begin
		stable_nxt = (sync2_r == sync3_r) ? sync3_r : stable_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r  <= 1'b0;
			sync2_r  <= 1'b0;
			sync3_r  <= 1'b0;
			stable_r <= 1'b0;
		end else begin
			sync1_r  <= osc_stable_pin;
			sync2_r  <= sync1_r;
			sync3_r  <= sync2_r;
			stable_r <= stable_nxt;
		end
	end

	assign osc_enable = osc_en_r;

	// ************************************************************
	// Transmit engine
	// ************************************************************
	assign carrier_req = mode_r[1] && (dac_r == DAC_CARRIER);
	assign tx_valid    = (state_r == ST_HEADER) || (state_r == ST_PAYLOAD);
	assign take        = tx_valid && tx_ready;
	assign tx_data     = byte_r;

	// Next state of the sequencer, the byte on offer and the pattern sources.
	always_comb begin
		state_nxt  = state_r;
		byte_nxt   = byte_r;
		crc_nxt    = crc_r;
		rd_ptr_nxt = rd_ptr_r;
		sent_nxt   = sent_r;
		hdr_nxt    = hdr_r;
		if (stb_tx_off) begin
			state_nxt = ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					// Without a stable oscillator the transmit strobe is ignored.
					if (stb_tx_on && stable_r) begin
						state_nxt  = ST_HEADER;
						byte_nxt   = PREAMBLE_BYTE;
						hdr_nxt    = 3'd1;
						crc_nxt    = CRC_RST;
						rd_ptr_nxt = '0;
						sent_nxt   = '0;
					end
				end
				ST_HEADER: begin
					if (take) begin
						if (hdr_r < 3'(PREAMBLE_LEN)) begin
							byte_nxt = PREAMBLE_BYTE;
							hdr_nxt  = hdr_r + 3'd1;
						end else if (hdr_r == 3'(PREAMBLE_LEN)) begin
							byte_nxt = SFD_BYTE;
							hdr_nxt  = hdr_r + 3'd1;
						end else if (carrier_req) begin
							state_nxt = ST_CARRIER;
						end else if (mode_r == MODE_PRBS) begin
							// First payload byte is the low byte of the cleared CRC.
							state_nxt = ST_PAYLOAD;
							byte_nxt  = crc_r[7:0];
							crc_nxt   = crc_step(crc_r, CRC_FEED);
						end else if (mode_r == MODE_REPLAY || count_r != '0) begin
							state_nxt  = ST_PAYLOAD;
							byte_nxt   = mem[rd_ptr_r];
							rd_ptr_nxt = rd_ptr_r + 1'b1;
							sent_nxt   = sent_r + 1'b1;
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
				ST_PAYLOAD: begin
					if (take) begin
						if (mode_r == MODE_PRBS) begin
							// The 16-bit state cycles through 32767 values before repeating.
							byte_nxt = crc_r[7:0];
							crc_nxt  = crc_step(crc_r, CRC_FEED);
						end else if (mode_r == MODE_REPLAY) begin
							// Pointer wraps over the whole buffer; underflow is never checked.
							byte_nxt   = mem[rd_ptr_r];
							rd_ptr_nxt = rd_ptr_r + 1'b1;
						end else if (sent_r < count_r) begin
							byte_nxt   = mem[rd_ptr_r];
							rd_ptr_nxt = rd_ptr_r + 1'b1;
							sent_nxt   = sent_r + 1'b1;
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
				ST_CARRIER: begin
					// Carrier stays until stopped, the override value is withdrawn or the test selection leaves 2 and 3.
					if (!carrier_req) begin
						state_nxt = ST_IDLE;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// Register stage of the transmit engine.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r  <= ST_IDLE;
			byte_r   <= 8'h00;
			crc_r    <= CRC_RST;
			rd_ptr_r <= '0;
			sent_r   <= '0;
			hdr_r    <= 3'd0;
		end else begin
			state_r  <= state_nxt;
			byte_r   <= byte_nxt;
			crc_r    <= crc_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			sent_r   <= sent_nxt;
			hdr_r    <= hdr_nxt;
		end
	end

	// The transmitter is on in every active state; static drive only for the carrier.
	// Override drops at once when the carrier value is withdrawn, not one cycle later.
	assign tx_enable = (state_r != ST_IDLE);
	assign dac_drive = '{override_en: (state_r == ST_CARRIER) && carrier_req, value: dac_r};

endmodule // tx_test_pattern_generator
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import txtest_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] b, crc_b;
	logic [15:0] crc;
	logic hreadyout, hresp, osc_enable, osc_stable_pin, tx_valid, tx_ready, tx_enable;
	logic [7:0] tx_data;
	dac_drive_s dac_drive;
	int bad_count = 0, check_count = 0;
	logic [7:0] prbs_tab [7] = '{8'h00, 8'h78, 8'hB8, 8'h4B, 8'h99, 8'hC3, 8'hE9};

	always #10 hclk = ~hclk;

	tx_test_pattern_generator u_tx_test_pattern_generator (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_enable(osc_enable),
		.osc_stable_pin(osc_stable_pin), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_enable(tx_enable), .dac_drive(dac_drive));
	txtest_partner u_txtest_partner (.hclk(hclk), .hresetn(hresetn), .osc_enable(osc_enable), .slow(slow),
		.osc_stable_pin(osc_stable_pin), .tx_ready(tx_ready));

	// ****************
	// Tasks
	// ****************
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h got %h", name, exp, got);
		end
	endtask

	// One AHB single transfer; every wait is bounded and a hang ends the run.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		q = hrdata;
		if (n >= 100) begin bad_count++; summarize(); end
	endtask

	// Waits for the next accepted byte.
	task automatic take();
		int n;
		n = 0;
		do begin @(negedge hclk); n++; end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 200);
		b = tx_data;
		if (n >= 200) begin bad_count++; summarize(); end
		else @(posedge hclk);
	endtask

	task automatic start(input logic [1:0] m);
		bus(1, OFS_MODE, {30'h0, m});
		bus(1, OFS_STROBE, 32'h0000_0002);
		for (int i = 0; i < 5; i++) begin
			take();
			chk("header", (i < 4) ? 32'h0000_0000 : 32'h0000_00A7, {24'h0, b});
		end
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		bus(1, OFS_STROBE, 32'h0000_0002);
		bus(0, OFS_STATUS, 0);
		chk("on before osc", 32'h0000_0000, q & 32'h0000_000E);
		bus(1, OFS_STROBE, 32'h0000_0001);
		repeat (40) bus(0, OFS_STATUS, 0);
		chk("osc", 32'h0000_0003, q & 32'h0000_0003);
		bus(0, 8'h20, 0);
		chk("unmapped", 32'h0000_0000, q);
		chk("unmapped resp", 32'h0000_0000, {31'h0, hresp});
		// Pseudo-random run: bytes follow the LSB-first CRC fed with all ones.
		start(MODE_PRBS);
		crc = CRC_RST;
		for (int i = 0; i < 12; i++) begin
			take();
			crc_b = crc[7:0];
			if (i < 7) chk("prbs table", {24'h0, prbs_tab[i]}, {24'h0, b});
			chk("prbs crc", {24'h0, crc_b}, {24'h0, b});
			for (int k = 0; k < 8; k++) crc = (crc >> 1) ^ ((crc[0] ^ CRC_FEED[k]) ? CRC_POLY_REFL : 16'h0000);
		end
		bus(1, OFS_STROBE, 32'h0000_0004);
		// Replay of a full buffer with a stalling modulator; the extra write is dropped.
		slow <= 1;
		bus(1, OFS_STROBE, 32'h0000_0008);
		for (int i = 0; i < 129; i++) bus(1, OFS_TXBUF, {24'h0, 8'(i) ^ 8'h5A});
		bus(0, OFS_STATUS, 0);
		chk("count", 32'h0000_0080, (q >> 8) & 32'h0000_00FF);
		start(MODE_REPLAY);
		for (int i = 0; i < 131; i++) begin
			take();
			chk("replay", {24'h0, 8'(i % 128) ^ 8'h5A}, {24'h0, b});
		end
		bus(1, OFS_STROBE, 32'h0000_0004);
		slow <= 0;
		// Carrier in both test selections.
		for (int m = 2; m < 4; m++) begin
			bus(1, OFS_DAC, {16'h0, DAC_CARRIER});
			start(2'(m));
			repeat (2) @(posedge hclk);
			chk("carrier", 32'h0000_0003, {30'h0, dac_drive.override_en, tx_enable & !tx_valid});
			chk("dac value", {16'h0, DAC_CARRIER}, {16'h0, dac_drive.value});
			bus(1, OFS_STROBE, 32'h0000_0004);
			bus(1, OFS_DAC, 32'h0000_0000);
		end
		// Normal packets send what is buffered and then stop.
		for (int m = 0; m < 2; m++) begin
			bus(1, OFS_STROBE, 32'h0000_0008);
			bus(1, OFS_TXBUF, 32'h0000_00AA);
			bus(1, OFS_TXBUF, 32'h0000_0055);
			start(2'(m));
			take();
			chk("packet 0", 32'h0000_00AA, {24'h0, b});
			take();
			chk("packet 1", 32'h0000_0055, {24'h0, b});
			repeat (3) @(posedge hclk);
			chk("packet end", 32'h0000_0000, {30'h0, tx_enable, dac_drive.override_en});
		end
		summarize();
	end
endmodule // tb_top
`default_nettype wire

/* File: sim/tx_test_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_test_props
	import txtest_pkg::*;
(
	// Clock and reset.
	input wire logic       hclk,
	input wire logic       hresetn,
	// Stream and drive.
	input wire logic       osc_enable,
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       tx_enable,
	input wire dac_drive_s dac_drive
);
	// ************
	// Take counter
	// ************
	logic [2:0] take_cnt_r;
	logic [2:0] take_cnt_nxt;

	// Counts takes since the transmitter came on; it saturates so it never wraps back into the header.
	always_comb begin
		take_cnt_nxt = take_cnt_r;
		if (!tx_enable)
			take_cnt_nxt = 3'h0;
		else if (tx_valid && tx_ready && take_cnt_r != 3'h7)
			take_cnt_nxt = take_cnt_r + 3'h1;
	end

	// Registers the count.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			take_cnt_r <= 3'h0;
		else
			take_cnt_r <= take_cnt_nxt;
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	carrier_static_a: assert property (dac_drive.override_en |->
		tx_enable && !tx_valid && dac_drive.value == DAC_CARRIER) else $error("carrier drive wrong");
	preamble_bytes_a: assert property (tx_valid && take_cnt_r < 3'h4 |-> tx_data == PREAMBLE_BYTE)
		else $error("preamble byte wrong");
	sfd_byte_a: assert property (tx_valid && take_cnt_r == 3'h4 |-> tx_data == SFD_BYTE)
		else $error("delimiter byte wrong");
	carrier_after_hdr_a: assert property ($rose(dac_drive.override_en) |-> take_cnt_r == 3'h5)
		else $error("carrier without header");
	byte_hold_a: assert property (tx_valid && !tx_ready |=> !tx_valid || $stable(tx_data))
		else $error("byte changed before take");
	valid_enable_a: assert property (tx_valid |-> tx_enable) else $error("byte offered while off");
	no_override_a: assert property (tx_valid |-> !dac_drive.override_en) else $error("override on data");
	osc_first_a: assert property ($rose(tx_enable) |-> osc_enable) else $error("transmit before osc");
endmodule // tx_test_props

bind tx_test_pattern_generator tx_test_props u_tx_test_props (.hclk(hclk), .hresetn(hresetn),
	.osc_enable(osc_enable), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_enable(tx_enable), .dac_drive(dac_drive));
`default_nettype wire

/* File: sim/txtest_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module txtest_partner (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Oscillator and modulator.
	input wire logic osc_enable,
	input wire logic slow,
	output logic     osc_stable_pin,
	output logic     tx_ready
);
	logic [3:0] warm_r;
	logic [3:0] warm_nxt;
	logic [1:0] tick_r;
	logic [1:0] tick_nxt;

	// The crystal needs time to settle, so stability lags the enable.
	always_comb begin
		warm_nxt = (osc_enable && warm_r != 4'hF) ? warm_r + 4'h1 : warm_r;
		tick_nxt = tick_r + 2'h1;
	end

	// Registers the warm-up and stall counters.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			warm_r <= 4'h0;
			tick_r <= 2'h0;
		end else begin
			warm_r <= warm_nxt;
			tick_r <= tick_nxt;
		end
	end

	// A slow modulator accepts one byte in four cycles.
	assign osc_stable_pin = (warm_r == 4'hF);
	assign tx_ready = !slow || tick_r == 2'h0;
endmodule // txtest_partner
`default_nettype wire
